// ==== rtl/sipo_map.vh ====
// Purpose: Constants for the serial-in parallel-out latch
// Assumes: Included by rtl/sipo_latch.v
// Notes:   Definitions only
`ifndef SIPO_MAP_VH
`define SIPO_MAP_VH
`define SIPO_WIDTH      8
`define SIPO_SHIFT_RST  8'h00
`define SIPO_STORE_RST  8'h00
`define SIPO_LAST_BIT   7
`endif

// ==== rtl/sipo_latch.v ====
// Purpose: Eight-bit serial-in shift register feeding a storage register
// Assumes: All pins synchronous to i_mclk; clocks edge-detected on it
// Assumes: Each pin clock is sampled low once between two of its edges
// Notes:   Parallel outputs change in the same i_mclk cycle as the storage register
// Notes:   Clears are level-sensitive and sampled on i_mclk
// Notes:   No software-visible registers
// How it works
// - Eight-stage shift register feeds an eight-bit storage register.
// - Shift and storage registers each have own clock and own clear.
// - Cascade output lets several devices chain into one long chain.
// - Shift and storage clocks act on rising edges only.
// - Common clock: storage takes shift contents from before that edge.
// - Shift clear low forces all shift stages to zero.
// - Shift edge: first stage takes input bit, others take previous stage.
// - Shift clock falling edge leaves shift register unchanged.
// - Storage clear low forces all storage bits to zero.
// - Storage edge loads all eight shift register bits.
// - Storage clock falling edge leaves storage register unchanged.
`timescale 1ns/10ps
`include "sipo_map.vh"

module sipo_latch (
   // Clock and reset
   input  wire                   i_mclk,
   input  wire                   i_rst,
   // Shift side
   input  wire                   i_bit_input,
   input  wire                   i_shift_clock,
   input  wire                   i_shift_clear_n,
   // Storage side
   input  wire                   i_storage_clock,
   input  wire                   i_storage_clear_n,
   // Outputs
   output wire [`SIPO_WIDTH-1:0] o_parallel_outputs,
   output wire                   o_cascade_out
);

   // Widths and reset values
   localparam                   WIDTH     = `SIPO_WIDTH;
   localparam                   LAST      = `SIPO_LAST_BIT;
   localparam [`SIPO_WIDTH-1:0] SHIFT_RST = `SIPO_SHIFT_RST;
   localparam [`SIPO_WIDTH-1:0] STORE_RST = `SIPO_STORE_RST;

   // Rising transition between two samples of a pin
   // Used for both pin clocks
   function rise_seen;
      input now_lvl;
      input was_lvl;
      begin
         rise_seen = now_lvl & ~was_lvl;
      end
   endfunction

   // Edge history
   reg              shift_clk_q;
   reg              shift_clk_d;
   reg              store_clk_q;
   reg              store_clk_d;
   wire             shift_rise;
   wire             store_rise;

   // Shift path
   wire             shift_clr;
   wire [WIDTH-1:0] shift_q;
   wire [WIDTH-1:0] shift_d;
   genvar           gi;

   // Storage path
   wire             store_clr;
   wire [WIDTH-1:0] store_q;
   wire [WIDTH-1:0] store_d;
   genvar           gs;

   // Outputs
   wire [WIDTH-1:0] par_q;
   reg              casc_q;
   reg              casc_d;
   genvar           go;

   // Clears and rising edges
   assign shift_clr  = ~i_shift_clear_n;
   assign store_clr  = ~i_storage_clear_n;
   assign shift_rise = rise_seen(i_shift_clock, shift_clk_q);
   assign store_rise = rise_seen(i_storage_clock, store_clk_q);

   // Edge history follows the pin levels
   always @* begin
      shift_clk_d = i_shift_clock;
   end

   always @* begin
      store_clk_d = i_storage_clock;
   end

   // History resets low, so a clock high at release is an edge
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         shift_clk_q <= 1'b0;
      end else begin
         shift_clk_q <= shift_clk_d;
      end
   end

   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         store_clk_q <= 1'b0;
      end else begin
         store_clk_q <= store_clk_d;
      end
   end

   // One flip-flop per shift stage
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_stage
         wire stage_src;
         reg  stage_d;
         reg  stage_q;

         // Stage input: serial pin or the stage before
         if (gi == 0) begin : g_first
            assign stage_src = i_bit_input;
         end else begin : g_next
            assign stage_src = shift_q[gi-1];
         end

         // Clear overrides any edge; a falling edge holds
         always @* begin
            stage_d = stage_q;
            if (shift_clr) begin
               stage_d = SHIFT_RST[gi];
            end else if (shift_rise) begin
               stage_d = stage_src;
            end
         end

         always @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               stage_q <= SHIFT_RST[gi];
            end else begin
               stage_q <= stage_d;
            end
         end

         assign shift_q[gi] = stage_q;
         assign shift_d[gi] = stage_d;
      end
   endgenerate

   // Storage bits load the shift contents from before this edge
   generate
      for (gs = 0; gs < WIDTH; gs = gs + 1) begin : g_store
         reg bit_d;
         reg bit_q;

         // Storage clear never touches the shift path
         // Clear wins over a load in the same cycle
         always @* begin
            bit_d = bit_q;
            if (store_clr) begin
               bit_d = STORE_RST[gs];
            end else if (store_rise) begin
               bit_d = shift_q[gs];
            end
         end

         always @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               bit_q <= STORE_RST[gs];
            end else begin
               bit_q <= bit_d;
            end
         end

         assign store_q[gs] = bit_q;
         assign store_d[gs] = bit_d;
      end
   endgenerate

   // Cascade follows the next value of the last stage
   always @* begin
      casc_d = shift_d[LAST];
   end

   // Registered like the parallel outputs
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         casc_q <= 1'b0;
      end else begin
         casc_q <= casc_d;
      end
   end

   // One output flip-flop per storage bit, first stage on bit 0
   generate
      for (go = 0; go < WIDTH; go = go + 1) begin : g_out
         reg out_d;
         reg out_q;

         always @* begin
            out_d = store_d[go];
         end

         // Outputs come straight from flip-flops
         always @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               out_q <= STORE_RST[go];
            end else begin
               out_q <= out_d;
            end
         end

         assign par_q[go] = out_q;
      end
   endgenerate

   // Port drivers
   assign o_parallel_outputs = par_q;
   assign o_cascade_out      = casc_q;

endmodule // sipo_latch

// ==== test/sipo_ctl.sv ====
// Purpose: controller model Assumes: none Notes: none
`timescale 1ns/10ps
module sipo_ctl(input wire c, output reg b=0, sk=0, rk=0);
task lat; begin rk=1; @(negedge c); rk=0; @(negedge c); end endtask
task send(input [7:0] d); integer i; begin
for(i=7;i>=0;i=i-1) begin b=d[i]; sk=1; @(negedge c);
sk=0; b=~b; @(negedge c); end
lat; end endtask
task both(input x); begin b=x; sk=1; rk=1; @(negedge c);
sk=0; rk=0; @(negedge c); end endtask
endmodule // sipo_ctl

// ==== test/sipo_latch_monitor.sv ====
// Purpose: checks Assumes: none Notes: none
`timescale 1ns/10ps
module sipo_mon(input wire i_mclk,i_rst,i_shift_clock,i_shift_clear_n,
i_storage_clock,i_storage_clear_n,o_cascade_out,i_bit_input,
input wire [7:0] o_parallel_outputs);
default clocking @(posedge i_mclk); endclocking
default disable iff (i_rst);
property p_sc; !i_shift_clear_n|=>!o_cascade_out; endproperty
a_sc: assert property(p_sc) else $error("sc");
property p_rc; !i_storage_clear_n|=>o_parallel_outputs==8'h00; endproperty
a_rc: assert property(p_rc) else $error("rc");
property p_ld; i_storage_clear_n&&$rose(i_storage_clock)
|=>o_parallel_outputs[7]==$past(o_cascade_out); endproperty
a_ld: assert property(p_ld) else $error("ld");
property p_rh; i_storage_clear_n&&!$rose(i_storage_clock)
|=>$stable(o_parallel_outputs); endproperty
a_rh: assert property(p_rh) else $error("rh");
property p_sh; i_shift_clear_n&&!$rose(i_shift_clock)
|=>$stable(o_cascade_out); endproperty
a_sh: assert property(p_sh) else $error("sh");
sequence s_both; i_shift_clear_n&&i_storage_clear_n&&$rose(i_shift_clock)
&&$rose(i_storage_clock); endsequence
property p_lag; s_both|=>o_parallel_outputs[7]==$past(o_cascade_out);
endproperty
a_lag: assert property(p_lag) else $error("lag");
endmodule // sipo_mon
bind sipo_latch sipo_mon sipo_mon_i(.*);

// ==== test/sipo_latch_bench.sv ====
// Purpose: bench Assumes: none Notes: random bytes
`timescale 1ns/10ps
module sipo_latch_bench;
reg c=0, r=1, sc=1, rc=1; reg [7:0] d; wire [7:0] q; wire b, sk, rk;
wire cq; reg [31:0] rv;
integer seed=32'hbfbbb3b4, n_mismatch=0, comparisons=0, k;
initial forever #5 c=~c;
sipo_ctl sipo_ctl_i(.c(c),.b(b),.sk(sk),.rk(rk));
sipo_latch sipo_latch_i(.i_mclk(c),.i_rst(r),.i_bit_input(b),
.i_shift_clock(sk),.i_shift_clear_n(sc),.i_storage_clock(rk),
.i_storage_clear_n(rc),.o_parallel_outputs(q),.o_cascade_out(cq));
task chk(input [7:0] e, input ce); begin comparisons=comparisons+1;
if({q,cq}!=={e,ce}) begin n_mismatch=n_mismatch+1;
$display("Error %0t %h %h",$time,{q,cq},{e,ce}); end end endtask
task test_done; begin $display("%0d %0d",n_mismatch,comparisons);
if(n_mismatch==0&&comparisons>0) $display("*** PASS ***");
else $display("*** FAIL ***");
$finish; end endtask
initial begin #9000 n_mismatch=n_mismatch+1; test_done; end
initial begin repeat(2) @(negedge c); r=0;
for(k=0;k<20;k=k+1) begin rv=$random(seed); d=rv[7:0];
if(k<2) d=8'h80>>(k*7);
sipo_ctl_i.send(d); chk(d,d[7]);
if(k==5) begin sc=0; @(negedge c); sc=1; sipo_ctl_i.lat; chk(0,0); end
if(k==6) begin rc=0; @(negedge c); chk(0,d[7]); rc=1; end
if(k==7) begin sipo_ctl_i.both(1'b1); chk(d,d[6]); end
$display("test %0d done",k); end
test_done; end
endmodule // sipo_latch_bench
